// ==== hdl/bmp_consts.svh ====
// Constants for the boot-mode and programming-port block.
`ifndef BMP_CONSTS_SVH
`define BMP_CONSTS_SVH

// Register byte offsets.
`define BMP_CTRL_OFS 8'h00
`define BMP_STAT_OFS 8'h04

// Control register fields.
`define BMP_CTRL_FN_LSB 0
`define BMP_CTRL_FN_MSB 1
`define BMP_CTRL_GPO_BIT 2
`define BMP_CTRL_SYNC_BIT 3
`define BMP_CTRL_CKO_BIT 4
`define BMP_CTRL_CKOE_BIT 5
`define BMP_CTRL_RST 8'h00

// Status register fields.
`define BMP_STAT_SRC_LSB 0
`define BMP_STAT_SRC_MSB 1
`define BMP_STAT_PROGRAM_CABLE_CONNECTOR_BIT 2
`define BMP_STAT_BS0_BIT 3
`define BMP_STAT_BS1_BIT 4
`define BMP_STAT_CKI_BIT 5
`define BMP_STAT_FETCH_BIT 6

// AXI responses.
`define BMP_RESP_OKAY 2'h0
`define BMP_RESP_SLVERR 2'h2

// Clock and boot link timing.
`define BMP_CLK_HZ 25000000
`define BMP_BOOT_BAUD 2400
`define BMP_BAUD_DIV (`BMP_CLK_HZ / `BMP_BOOT_BAUD)

`endif

// ==== hdl/bmp_pkg.sv ====
// Types for the boot-mode and programming-port block.
package bmp_pkg;

  typedef enum logic [1:0] {
    BMP_FN_FETCH = 2'b00,
    BMP_FN_INTACK = 2'b01,
    BMP_FN_GPO = 2'b10,
    BMP_FN_RSVD = 2'b11
  } bmp_status_fn_t;

  // Index is {boot_select_0, boot_select_1}.
  typedef enum logic [1:0] {
    BMP_SRC_ZERO = 2'b00,
    BMP_SRC_SLAVE = 2'b01,
    BMP_SRC_CLOCKED = 2'b10,
    BMP_SRC_ASYNC = 2'b11
  } bmp_boot_src_t;

  typedef struct packed {
    logic clk_oe;
    logic clk_out;
    logic sync_mode;
    logic gpo;
    bmp_status_fn_t fn;
  } bmp_ctrl_t;

endpackage

// ==== hdl/bmp_port.sv ====
// Boot-mode select, status pin, reset and programming-port serial control.
//
// Contract
// - After reset, boot-select inputs choose cold boot or run from zero.
// - Program or run mode comes from boot-select levels at reset.
// - Cable attached drives both selects high; enter program mode.
// - No cable leaves both selects low; enter run mode.
// - Download and debug accepted only in program mode; only debug is gated here, the serial pins pass data in every mode.
// - Status function one drives low on the first opcode fetch.
// - Status function two drives low during interrupt acknowledge.
// - Status function three is a software general-purpose output.
// - Active-low external reset resets processor and peripherals.
// - Serial port runs synchronous, or asynchronous with clock as GPIO.
// - While running, selects read as inputs, status usable as output.
// - Encoding: 00 zero, 01 slave, 10 clocked, 11 async 2400.
`timescale 1ns/1ps
`default_nettype none
`include "bmp_consts.svh"

module bmp_port #(
  parameter int BOOT_BAUD_DIV = `BMP_BAUD_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic boot_select_0,
  input wire logic boot_select_1,
  input wire logic ext_reset_n,
  output logic periph_reset_n,
  output logic cold_boot,
  output logic exec_from_zero,
  output logic program_mode,
  output logic [1:0] boot_src,
  output logic boot_baud_tick,
  input wire logic opcode_fetch,
  input wire logic int_ack,
  output logic status_pin,
  input wire logic dbg_req,
  output logic dbg_grant,
  input wire logic ser_txd,
  output logic ser_rxd,
  input wire logic ser_clk_out,
  input wire logic ser_clk_oe,
  output logic ser_clk_in,
  output logic txd_pin,
  input wire logic rxd_pin,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset and boot-select latch.

  logic rst_all;
  logic in_rst_r;
  logic [1:0] src_r;
  logic program_cable_connector_r;
  logic [15:0] baud_cnt_r;

  // The external reset joins the bus reset here; the bus slave and control register use the bus reset only.
  assign rst_all = !aresetn || !ext_reset_n;

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      in_rst_r <= 1'b1;
    end else begin
      in_rst_r <= 1'b0;
    end
  end

  // The latch is taken on the first clock after release, so a pin that
  // moves later (cable pulled) cannot change the mode of a running core.
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      src_r <= 2'b00;
      program_cable_connector_r <= 1'b0;
    end else if (in_rst_r) begin
      src_r <= {boot_select_0, boot_select_1};
      program_cable_connector_r <= boot_select_0 && boot_select_1;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      periph_reset_n <= 1'b0;
      cold_boot <= 1'b0;
      exec_from_zero <= 1'b0;
      program_mode <= 1'b0;
      boot_src <= 2'b00;
    end else begin
      periph_reset_n <= !in_rst_r;
      cold_boot <= !in_rst_r && (src_r != bmp_pkg::BMP_SRC_ZERO);
      exec_from_zero <= !in_rst_r && (src_r == bmp_pkg::BMP_SRC_ZERO);
      program_mode <= !in_rst_r && program_cable_connector_r;
      boot_src <= src_r;
    end
  end

  // Bit clock for the asynchronous cold boot at the fixed boot rate.
  always_ff @(posedge aclk) begin
    if (rst_all || in_rst_r || src_r != bmp_pkg::BMP_SRC_ASYNC) begin
      baud_cnt_r <= 16'h0000;
      boot_baud_tick <= 1'b0;
    end else if (baud_cnt_r == 16'(BOOT_BAUD_DIV - 1)) begin
      baud_cnt_r <= 16'h0000;
      boot_baud_tick <= 1'b1;
    end else begin
      baud_cnt_r <= baud_cnt_r + 16'h0001;
      boot_baud_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and the status pin.

  bmp_pkg::bmp_ctrl_t ctrl_r;
  logic fetch_seen_r;

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      fetch_seen_r <= 1'b0;
    end else if (opcode_fetch) begin
      fetch_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      status_pin <= 1'b1;
    end else begin
      case (ctrl_r.fn)
        bmp_pkg::BMP_FN_FETCH: begin
          status_pin <= !(opcode_fetch && !fetch_seen_r);
        end
        bmp_pkg::BMP_FN_INTACK: begin
          status_pin <= !int_ack;
        end
        bmp_pkg::BMP_FN_GPO: begin
          status_pin <= ctrl_r.gpo;
        end
        default: begin
          status_pin <= 1'b1;
        end
      endcase
    end
  end

  // Debug requests from the link are dropped outside program mode.
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      dbg_grant <= 1'b0;
    end else begin
      dbg_grant <= dbg_req && program_cable_connector_r && !in_rst_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port pins.

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      txd_pin <= 1'b1;
      ser_rxd <= 1'b1;
      sclk_o <= 1'b0;
      sclk_oe <= 1'b0;
      ser_clk_in <= 1'b0;
    end else begin
      txd_pin <= ser_txd;
      ser_rxd <= rxd_pin;
      ser_clk_in <= sclk_i;
      if (ctrl_r.sync_mode) begin
        sclk_o <= ser_clk_out;
        sclk_oe <= ser_clk_oe;
      end else begin
        sclk_o <= ctrl_r.clk_out;
        sclk_oe <= ctrl_r.clk_oe;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic [7:0] wa;
  logic [7:0] wd;
  logic wl;
  logic aw_have_nxt;
  logic w_have_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `BMP_CTRL_OFS) || (a == `BMP_STAT_OFS);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `BMP_CTRL_OFS) begin
      v[5:0] = ctrl_r;
    end else if (a == `BMP_STAT_OFS) begin
      v[`BMP_STAT_SRC_MSB:`BMP_STAT_SRC_LSB] = src_r;
      v[`BMP_STAT_PROGRAM_CABLE_CONNECTOR_BIT] = program_cable_connector_r;
      v[`BMP_STAT_BS0_BIT] = boot_select_0;
      v[`BMP_STAT_BS1_BIT] = boot_select_1;
      v[`BMP_STAT_CKI_BIT] = sclk_i;
      v[`BMP_STAT_FETCH_BIT] = fetch_seen_r;
    end
    read_word = v;
  endfunction

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    wa = aw_have_r ? aw_addr_r : s_axi_awaddr;
    wd = w_have_r ? w_data_r : s_axi_wdata[7:0];
    wl = w_have_r ? w_lane_r : s_axi_wstrb[0];
    wr_fire = (aw_have_r || aw_take) && (w_have_r || w_take) &&
              !s_axi_bvalid;
    aw_have_nxt = (aw_have_r || aw_take) && !wr_fire;
    w_have_nxt = (w_have_r || w_take) && !wr_fire;
    bvalid_nxt = wr_fire || (s_axi_bvalid && !s_axi_bready);
    rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BMP_RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      s_axi_awready <= !aw_have_nxt && !bvalid_nxt;
      s_axi_wready <= !w_have_nxt && !bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bresp <= addr_hit(wa) ? `BMP_RESP_OKAY : `BMP_RESP_SLVERR;
      end
    end
  end

  // Control survives the external reset so the port setup is kept;
  // only the bus reset clears it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= bmp_pkg::bmp_ctrl_t'(6'(`BMP_CTRL_RST));
    end else if (wr_fire && wl && wa == `BMP_CTRL_OFS) begin
      ctrl_r <= bmp_pkg::bmp_ctrl_t'(wd[5:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BMP_RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= read_word(s_axi_araddr);
        s_axi_rresp <= addr_hit(s_axi_araddr) ? `BMP_RESP_OKAY :
                       `BMP_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_boot_src;
    !rst_all && $past(in_rst_r) && !$past(rst_all) |->
      src_r == $past({boot_select_0, boot_select_1});
  endproperty
  a_boot_src: assert property (p_boot_src)
    else $error("boot source not latched from selects");

  property p_program_cable_connector_mode;
    !rst_all && $past(in_rst_r) && !$past(rst_all) |->
      program_cable_connector_r == $past(boot_select_0 && boot_select_1);
  endproperty
  a_program_cable_connector_mode: assert property (p_program_cable_connector_mode)
    else $error("mode not taken from select levels");

  property p_cable_program_cable_connector;
    ext_reset_n && in_rst_r && !rst_all && boot_select_0 && boot_select_1
      ##1 ext_reset_n [*2] |-> program_mode;
  endproperty
  a_cable_program_cable_connector: assert property (p_cable_program_cable_connector)
    else $error("cable attached but not in program mode");

  property p_no_cable_run;
    ext_reset_n && in_rst_r && !boot_select_0 && !boot_select_1
      ##1 ext_reset_n [*2] |-> !program_mode && exec_from_zero;
  endproperty
  a_no_cable_run: assert property (p_no_cable_run)
    else $error("no cable but not in run mode from zero");

  property p_dbg_gate;
    dbg_grant |-> program_mode || $past(program_cable_connector_r);
  endproperty
  a_dbg_gate: assert property (p_dbg_gate)
    else $error("debug granted outside program mode");

  property p_fetch_low;
    !rst_all && ctrl_r.fn == bmp_pkg::BMP_FN_FETCH && opcode_fetch &&
      !fetch_seen_r ##1 !rst_all |-> !status_pin;
  endproperty
  a_fetch_low: assert property (p_fetch_low)
    else $error("status not low on first fetch");

  property p_intack;
    !rst_all && ctrl_r.fn == bmp_pkg::BMP_FN_INTACK ##1 !rst_all |->
      status_pin == !$past(int_ack);
  endproperty
  a_intack: assert property (p_intack)
    else $error("status does not follow acknowledge");

  property p_gpo;
    !rst_all && ctrl_r.fn == bmp_pkg::BMP_FN_GPO ##1 !rst_all |->
      status_pin == $past(ctrl_r.gpo);
  endproperty
  a_gpo: assert property (p_gpo)
    else $error("status does not follow software value");

  property p_ext_reset;
    !ext_reset_n |=> !periph_reset_n && !cold_boot && !program_mode;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("external reset did not reset outputs");

  property p_sclk_mux;
    !rst_all ##1 !rst_all |-> sclk_oe == ($past(ctrl_r.sync_mode) ?
      $past(ser_clk_oe) : $past(ctrl_r.clk_oe));
  endproperty
  a_sclk_mux: assert property (p_sclk_mux)
    else $error("clock pin enable from wrong source");

  property p_hold;
    !rst_all && !in_rst_r ##1 !rst_all |-> $stable(src_r) && $stable(program_cable_connector_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched mode changed without reset");

  property p_baud;
    boot_baud_tick ##1 !rst_all [*2] |-> !boot_baud_tick;
  endproperty
  a_baud: assert property (p_baud)
    else $error("boot bit clock ticks too often");

  c_program_cable_connector: cover property (program_mode && dbg_grant);
  c_run: cover property (exec_from_zero ##1 !status_pin);
  c_write: cover property (wr_fire ##1 s_axi_bvalid);
  c_read: cover property (ar_take ##1 s_axi_rvalid);

endmodule // bmp_port

`default_nettype wire

// ==== verification/bmp_host_model.sv ====
// Host-side model: programming cable, board straps and the host link.
`timescale 1ns/1ps
`default_nettype none
module bmp_host_model (
  input wire logic cable,
  input wire logic [1:0] strap,
  input wire logic host_reset,
  input wire logic host_tx,
  input wire logic host_clk,
  input wire logic txd_pin,
  output logic boot_select_0,
  output logic boot_select_1,
  output logic ext_reset_n,
  output logic rxd_pin,
  output logic sclk_i,
  output logic host_rx
);
  // The cable pulls both selects high; otherwise pull-downs win unless
  // the board straps a select high.
  assign boot_select_0 = cable | strap[1];
  assign boot_select_1 = cable | strap[0];
  assign ext_reset_n = ~host_reset;
  assign rxd_pin = host_tx;
  assign sclk_i = host_clk;
  assign host_rx = txd_pin;
endmodule // bmp_host_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the boot-mode and programming-port block.
`timescale 1ns/1ps
`default_nettype none
`include "bmp_consts.svh"
module testbench;
  logic aclk, aresetn, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, boot_src, strap;
  logic bs0, bs1, ext_n, prst_n, cold, zero, program_cable_connector, tick, fetch, iack;
  logic stat_pin, dreq, dgnt, stxd, srxd, sco, scoe, sci, txd, rxd, scki;
  logic sclk_o, sclk_oe, cable, hrst, htx, hclk, hrx;
  logic [3:0] wstrb;
  int n_fail, n_checks;

  bmp_port #(.BOOT_BAUD_DIV(4)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready),
    .boot_select_0(bs0), .boot_select_1(bs1), .ext_reset_n(ext_n),
    .periph_reset_n(prst_n), .cold_boot(cold), .exec_from_zero(zero),
    .program_mode(program_cable_connector), .boot_src(boot_src), .boot_baud_tick(tick),
    .opcode_fetch(fetch), .int_ack(iack), .status_pin(stat_pin),
    .dbg_req(dreq), .dbg_grant(dgnt), .ser_txd(stxd), .ser_rxd(srxd),
    .ser_clk_out(sco), .ser_clk_oe(scoe), .ser_clk_in(sci),
    .txd_pin(txd), .rxd_pin(rxd), .sclk_i(scki), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe)
  );

  bmp_host_model host_u (
    .cable(cable), .strap(strap), .host_reset(hrst), .host_tx(htx),
    .host_clk(hclk), .txd_pin(txd), .boot_select_0(bs0),
    .boot_select_1(bs1), .ext_reset_n(ext_n), .rxd_pin(rxd),
    .sclk_i(scki), .host_rx(hrx)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // The bus tasks wait as long as the slave needs; a missing answer is
  // left to the watchdog, so no cycle count of the slave is assumed here.
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Hard reset from the host while the cable and straps are set up.
  task automatic boot(input logic c, input logic [1:0] s);
    @(posedge aclk);
    cable <= c;
    strap <= s;
    hrst <= 1'b1;
    wait_c(2);
    chk(prst_n, 0);
    @(posedge aclk);
    hrst <= 1'b0;
    wait_c(4);
    chk(prst_n, 1);
  endtask

  initial begin
    #1_000_000;
    n_fail++;
    stop_test();
  end

  initial begin
    logic [1:0] e, r;
    logic p;
    logic [31:0] d, k;
    {aresetn, awv, wv, bready, arv, rready, fetch, iack, dreq} = '0;
    {awaddr, araddr, wdata, strap} = '0;
    wstrb = 4'hf;
    {stxd, sco, scoe, cable, hrst, hclk} = '0;
    htx = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`BMP_CTRL_OFS, d, r);
    chk(d, 32'h0);
    chk(r, `BMP_RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      e = (i == 4) ? 2'b11 : 2'(i);
      p = (e == 2'b11);
      boot(i == 4, (i == 4) ? 2'b00 : 2'(i));
      chk(boot_src, e);
      chk(cold, e != 2'b00);
      chk(zero, e == 2'b00);
      chk(program_cable_connector, p);
      axr(`BMP_STAT_OFS, d, r);
      chk(d & 32'h1f, {27'h0, e[0], e[1], p, e});
      @(posedge aclk);
      dreq <= 1'b1;
      wait_c(2);
      chk(dgnt, p);
      @(posedge aclk);
      dreq <= 1'b0;
      k = '0;
      repeat (16) begin
        @(posedge aclk);
        #1;
        k = k + tick;
      end
      chk(k, (e == 2'b11) ? 4 : 0);
    end
    boot(1'b0, 2'b00);
    // Only the first fetch after reset marks the pin.
    for (int j = 0; j < 2; j++) begin
      @(posedge aclk);
      fetch <= 1'b1;
      @(posedge aclk);
      fetch <= 1'b0;
      #1;
      chk(stat_pin, j);
      wait_c(1);
      chk(stat_pin, 1);
    end
    @(posedge aclk);
    cable <= 1'b1;
    wait_c(3);
    chk(boot_src, 2'b00);
    chk(program_cable_connector, 0);
    axr(`BMP_STAT_OFS, d, r);
    chk(d[6:3], 4'b1011);
    axw(`BMP_CTRL_OFS, 32'h3f, r);
    chk(r, `BMP_RESP_OKAY);
    axr(`BMP_CTRL_OFS, d, r);
    chk(d, 32'h3f);
    // A write with lane 0 masked off is acknowledged and changes nothing.
    wstrb <= 4'h0;
    axw(`BMP_CTRL_OFS, 32'h00, r);
    wstrb <= 4'hf;
    chk(r, `BMP_RESP_OKAY);
    axr(`BMP_CTRL_OFS, d, r);
    chk(d, 32'h3f);
    axw(8'h08, 32'h1, r);
    chk(r, `BMP_RESP_SLVERR);
    axr(8'h08, d, r);
    chk(d, 32'h0);
    chk(r, `BMP_RESP_SLVERR);
    axw(`BMP_CTRL_OFS, 32'h01, r);
    @(posedge aclk);
    iack <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      @(posedge aclk);
      if (j == 2) iack <= 1'b0;
      #1;
      chk(stat_pin, 0);
    end
    wait_c(1);
    chk(stat_pin, 1);
    for (int j = 0; j < 2; j++) begin
      axw(`BMP_CTRL_OFS, j ? 32'h6 : 32'h2, r);
      wait_c(2);
      chk(stat_pin, j);
    end
    @(posedge aclk);
    sco <= 1'b1;
    scoe <= 1'b1;
    stxd <= 1'b0;
    htx <= 1'b0;
    hclk <= 1'b1;
    axw(`BMP_CTRL_OFS, 32'h08, r);
    wait_c(2);
    chk({sclk_o, sclk_oe, hrx, srxd, sci}, 5'b11001);
    axw(`BMP_CTRL_OFS, 32'h20, r);
    wait_c(2);
    chk({sclk_o, sclk_oe}, 2'b01);
    axr(`BMP_STAT_OFS, d, r);
    chk(d[5], 1);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
